// File: logic/umfc_pkg.sv
// Constants, register map and carrier types for the modem flow control block
package umfc_pkg;
    localparam int UMFC_FIFO_DEPTH = 12;
    localparam int UMFC_CHAR_W = 8;
    localparam int UMFC_LVL_W = 4;
    localparam int UMFC_ADDR_W = 8;
    localparam logic [3:0] UMFC_THR_MAX = 4'hc;
    localparam logic [3:0] UMFC_THR_OFF = 4'h0;

    localparam logic [7:0] UMFC_OFS_CTRL = 8'h00;
    localparam logic [7:0] UMFC_OFS_OPT2 = 8'h04;
    localparam logic [7:0] UMFC_OFS_CHG1 = 8'h08;
    localparam logic [7:0] UMFC_OFS_LV1 = 8'h0c;
    localparam logic [7:0] UMFC_OFS_LV2 = 8'h10;
    localparam logic [7:0] UMFC_OFS_TXD = 8'h14;
    localparam logic [7:0] UMFC_OFS_RXD = 8'h18;
    localparam logic [7:0] UMFC_OFS_SPC = 8'h1c;
    localparam logic [7:0] UMFC_OFS_STAT = 8'h20;

    localparam int UMFC_CTRL_RXEN = 0;
    localparam int UMFC_CTRL_TXEN = 1;
    localparam int UMFC_OPT2_RXGATE = 0;
    localparam int UMFC_OPT2_CLRGATE = 1;
    localparam int UMFC_OPT2_REQAUTO = 2;
    localparam int UMFC_LV1_RTS = 0;
    localparam int UMFC_LV1_CTS = 4;
    localparam int UMFC_LV1_DSR = 5;
    localparam int UMFC_LV2_DTR = 1;
    localparam int UMFC_LV2_DSR = 5;
    localparam int UMFC_STAT_TXLVL = 8;
    localparam int UMFC_STAT_HOLD = 16;
    localparam int UMFC_STAT_OVR = 17;

    localparam logic [1:0] UMFC_CTRL_RST = 2'h0;
    localparam logic [2:0] UMFC_OPT2_RST = 3'h0;
    localparam logic [1:0] UMFC_RESP_OKAY = 2'h0;
    localparam logic [1:0] UMFC_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic en;
        logic [UMFC_ADDR_W-1:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } umfc_wreq_s;

    typedef struct packed {
        logic en;
        logic [UMFC_ADDR_W-1:0] addr;
    } umfc_rreq_s;
endpackage

// File: logic/umfc_fifo.sv
// Character FIFO with occupancy count, depth need not be a power of two
`timescale 1ns/1ps
module umfc_fifo
    import umfc_pkg::*;
#(
    parameter int WIDTH = UMFC_CHAR_W,
    parameter int DEPTH = UMFC_FIFO_DEPTH,
    parameter int LVL_W = UMFC_LVL_W
)
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_push,
    input wire logic [WIDTH-1:0] i_data,
    input wire logic i_pop,
    output logic [WIDTH-1:0] o_data,
    output logic [LVL_W-1:0] o_level,
    output logic o_empty,
    output logic o_full
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
    localparam logic [LVL_W-1:0] LVL_FULL = LVL_W'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [LVL_W-1:0] lvl_q, lvl_d;
    logic push_ok, pop_ok;

    assign o_empty = (lvl_q == '0);
    assign o_full = (lvl_q == LVL_FULL);
    assign o_level = lvl_q;
    assign o_data = mem[rp_q];
    assign push_ok = i_push && !o_full;
    assign pop_ok = i_pop && !o_empty;

    always_comb
    begin
        wp_d = wp_q;
        rp_d = rp_q;
        lvl_d = lvl_q;
        if (push_ok)
            wp_d = (wp_q == PTR_LAST) ? '0 : wp_q + 1'b1;
        if (pop_ok)
            rp_d = (rp_q == PTR_LAST) ? '0 : rp_q + 1'b1;
        if (push_ok && !pop_ok)
            lvl_d = lvl_q + 1'b1;
        else if (pop_ok && !push_ok)
            lvl_d = lvl_q - 1'b1;
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            wp_q <= '0;
            rp_q <= '0;
            lvl_q <= '0;
        end
        else
        begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            lvl_q <= lvl_d;
        end
    end

    // Storage has no reset; the count alone decides what is valid
    always_ff @(posedge i_clk)
    begin
        if (push_ok)
            mem[wp_q] <= i_data;
    end
endmodule

// File: logic/umfc_axil.sv
// AXI4-Lite slave front end, turns bus transfers into one-cycle register strobes
`timescale 1ns/1ps
module umfc_axil
    import umfc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [UMFC_ADDR_W-1:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [UMFC_ADDR_W-1:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output umfc_wreq_s o_wreq,
    output umfc_rreq_s o_rreq,
    input wire logic i_wok,
    input wire logic i_rok,
    input wire logic [31:0] i_rdata
);
    logic aw_v_q, aw_v_d, w_v_q, w_v_d, b_v_q, b_v_d, ar_v_q, ar_v_d, r_v_q, r_v_d;
    logic awr_q, awr_d, wr_q, wr_d, arr_q, arr_d;
    logic [UMFC_ADDR_W-1:0] aw_a_q, aw_a_d, ar_a_q, ar_a_d;
    logic [31:0] w_d_q, w_d_d, rdat_q, rdat_d;
    logic [3:0] w_s_q, w_s_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic wr_fire, rd_fire;

    assign wr_fire = aw_v_q && w_v_q && !b_v_q;
    assign rd_fire = ar_v_q && !r_v_q;
    assign o_wreq = '{en: wr_fire, addr: aw_a_q, data: w_d_q, strb: w_s_q};
    assign o_rreq = '{en: rd_fire, addr: ar_a_q};
    assign o_awready = awr_q;
    assign o_wready = wr_q;
    assign o_arready = arr_q;
    assign o_bvalid = b_v_q;
    assign o_bresp = bresp_q;
    assign o_rvalid = r_v_q;
    assign o_rdata = rdat_q;
    assign o_rresp = rresp_q;

    always_comb
    begin
        aw_v_d = aw_v_q;
        aw_a_d = aw_a_q;
        w_v_d = w_v_q;
        w_d_d = w_d_q;
        w_s_d = w_s_q;
        b_v_d = b_v_q;
        bresp_d = bresp_q;
        ar_v_d = ar_v_q;
        ar_a_d = ar_a_q;
        r_v_d = r_v_q;
        rdat_d = rdat_q;
        rresp_d = rresp_q;
        if (i_awvalid && awr_q)
        begin
            aw_v_d = 1'b1;
            aw_a_d = i_awaddr;
        end
        if (i_wvalid && wr_q)
        begin
            w_v_d = 1'b1;
            w_d_d = i_wdata;
            w_s_d = i_wstrb;
        end
        if (b_v_q && i_bready)
            b_v_d = 1'b0;
        if (wr_fire)
        begin
            aw_v_d = 1'b0;
            w_v_d = 1'b0;
            b_v_d = 1'b1;
            bresp_d = i_wok ? UMFC_RESP_OKAY : UMFC_RESP_SLVERR;
        end
        if (i_arvalid && arr_q)
        begin
            ar_v_d = 1'b1;
            ar_a_d = i_araddr;
        end
        if (r_v_q && i_rready)
            r_v_d = 1'b0;
        if (rd_fire)
        begin
            ar_v_d = 1'b0;
            r_v_d = 1'b1;
            rdat_d = i_rdata;
            rresp_d = i_rok ? UMFC_RESP_OKAY : UMFC_RESP_SLVERR;
        end
        // One transfer per direction in flight keeps read side effects exact
        awr_d = !aw_v_d && !b_v_d;
        wr_d = !w_v_d && !b_v_d;
        arr_d = !ar_v_d && !r_v_d;
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            aw_v_q <= 1'b0;
            aw_a_q <= '0;
            w_v_q <= 1'b0;
            w_d_q <= '0;
            w_s_q <= '0;
            b_v_q <= 1'b0;
            bresp_q <= UMFC_RESP_OKAY;
            ar_v_q <= 1'b0;
            ar_a_q <= '0;
            r_v_q <= 1'b0;
            rdat_q <= '0;
            rresp_q <= UMFC_RESP_OKAY;
            awr_q <= 1'b0;
            wr_q <= 1'b0;
            arr_q <= 1'b0;
        end
        else
        begin
            aw_v_q <= aw_v_d;
            aw_a_q <= aw_a_d;
            w_v_q <= w_v_d;
            w_d_q <= w_d_d;
            w_s_q <= w_s_d;
            b_v_q <= b_v_d;
            bresp_q <= bresp_d;
            ar_v_q <= ar_v_d;
            ar_a_q <= ar_a_d;
            r_v_q <= r_v_d;
            rdat_q <= rdat_d;
            rresp_q <= rresp_d;
            awr_q <= awr_d;
            wr_q <= wr_d;
            arr_q <= arr_d;
        end
    end
endmodule

// File: logic/umfc_top.sv
// Out-of-band flow control for one serial channel with its register file
// Notes on behaviour
// - Four-bit receive threshold 0 to 12; zero turns automatic DTR off.
// - Threshold and receiver on: DTR asserted while receive level below threshold.
// - At threshold DTR drops and stays low until reads lower the level.
// - Bit 1 of line_value_2 drives DTR by hand; one asserts it.
// - Receive gate enable discards characters received while DSR is deasserted.
// - Request auto output asserts RTS while transmit data is pending.
// - Auto RTS drops once everything is sent, until new data is written.
// - Without auto RTS, line_value_1 drives RTS by software.
// - Clear gate enable lets characters go only while CTS is asserted.
// - After CTS drops, the shifting and held characters still go out.
// - Gated transmission resumes by itself when CTS returns.
// - Special character send ignores CTS; the gate covers FIFO data only.
// - With automatic control off, the four pins act as general purpose I/O.
// - RTS and CTS belong to the transmitter, DTR and DSR to the receiver.
// - CTS is sampled on FIFO to holding moves, not holding to shifter.
// - Line value bits are inverted against pin levels.
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module umfc_top
    import umfc_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [UMFC_ADDR_W-1:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [UMFC_ADDR_W-1:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    input wire logic i_rx_valid,
    input wire logic [UMFC_CHAR_W-1:0] i_rx_char,
    output logic o_tx_valid,
    output logic [UMFC_CHAR_W-1:0] o_tx_char,
    input wire logic i_tx_ready,
    input wire logic i_tx_busy,
    input wire logic i_cts_b,
    input wire logic i_dsr_b,
    output logic o_rts_b,
    output logic o_dtr_b
);
    logic [1:0] rst_sync_q;
    logic rst_b;
    umfc_wreq_s wreq;
    umfc_rreq_s rreq;
    logic wok, rok;
    logic [31:0] rdata;

    logic [1:0] ctrl_q, ctrl_d;
    logic [2:0] opt2_q, opt2_d;
    logic [3:0] thr_q, thr_d;
    logic lv1_rts_q, lv1_rts_d, lv2_dtr_q, lv2_dtr_d;
    logic ovr_q, ovr_d;
    logic spc_v_q, spc_v_d, hold_v_q, hold_v_d;
    logic [UMFC_CHAR_W-1:0] spc_q, spc_d, hold_q, hold_d;
    logic rts_b_q, rts_b_d, dtr_b_q, dtr_b_d;

    logic rx_en, tx_en, rx_gate, clr_gate, req_auto, cts_on, dsr_on;
    logic rx_push, rx_pop, rx_empty, rx_full, tx_push, tx_pop, tx_empty, tx_full;
    logic [UMFC_CHAR_W-1:0] rx_head, tx_head;
    logic [UMFC_LVL_W-1:0] rx_level, tx_level;
    logic tx_pending, wr_byte0;

    // Reset is applied at once but released only after two clean edges
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_b = rst_sync_q[1];

    umfc_axil u_bus (
        .i_clk(i_sys_clk), .i_rst_b(rst_b),
        .i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr),
        .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
        .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
        .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
        .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp),
        .o_wreq(wreq), .o_rreq(rreq), .i_wok(wok), .i_rok(rok), .i_rdata(rdata)
    );

    umfc_fifo u_rx_fifo (
        .i_clk(i_sys_clk), .i_rst_b(rst_b), .i_push(rx_push), .i_data(i_rx_char),
        .i_pop(rx_pop), .o_data(rx_head), .o_level(rx_level), .o_empty(rx_empty), .o_full(rx_full)
    );

    umfc_fifo u_tx_fifo (
        .i_clk(i_sys_clk), .i_rst_b(rst_b), .i_push(tx_push), .i_data(wreq.data[UMFC_CHAR_W-1:0]),
        .i_pop(tx_pop), .o_data(tx_head), .o_level(tx_level), .o_empty(tx_empty), .o_full(tx_full)
    );

    assign rx_en = ctrl_q[UMFC_CTRL_RXEN];
    assign tx_en = ctrl_q[UMFC_CTRL_TXEN];
    assign rx_gate = opt2_q[UMFC_OPT2_RXGATE];
    assign clr_gate = opt2_q[UMFC_OPT2_CLRGATE];
    assign req_auto = opt2_q[UMFC_OPT2_REQAUTO];
    assign cts_on = !i_cts_b;
    assign dsr_on = !i_dsr_b;
    assign wr_byte0 = wreq.en && wreq.strb[0];

    // Characters complete on i_rx_valid; DSR is looked at in that same cycle
    assign rx_push = i_rx_valid && rx_en && !(rx_gate && !dsr_on);
    assign rx_pop = rreq.en && (rreq.addr == UMFC_OFS_RXD);
    assign tx_push = wr_byte0 && (wreq.addr == UMFC_OFS_TXD);
    assign tx_pending = !tx_empty || hold_v_q || spc_v_q || i_tx_busy;

    // Holding register feeds the external shifter; CTS is only consulted on the FIFO side
    assign tx_pop = !hold_v_q && !spc_v_q && tx_en && !tx_empty && (!clr_gate || cts_on);

    always_comb
    begin
        hold_v_d = hold_v_q;
        hold_d = hold_q;
        spc_v_d = spc_v_q;
        spc_d = spc_q;
        if (hold_v_q && i_tx_ready)
            hold_v_d = 1'b0;
        if (!hold_v_q && spc_v_q)
        begin
            hold_v_d = 1'b1;
            hold_d = spc_q;
            spc_v_d = 1'b0;
        end
        else if (tx_pop)
        begin
            hold_v_d = 1'b1;
            hold_d = tx_head;
        end
        if (wr_byte0 && (wreq.addr == UMFC_OFS_SPC) && !spc_v_q)
        begin
            spc_v_d = 1'b1;
            spc_d = wreq.data[UMFC_CHAR_W-1:0];
        end
    end

    // Register writes; a threshold above the FIFO size is clamped to it
    always_comb
    begin
        ctrl_d = ctrl_q;
        opt2_d = opt2_q;
        thr_d = thr_q;
        lv1_rts_d = lv1_rts_q;
        lv2_dtr_d = lv2_dtr_q;
        if (wr_byte0)
        begin
            unique case (wreq.addr)
                UMFC_OFS_CTRL: ctrl_d = wreq.data[1:0];
                UMFC_OFS_OPT2: opt2_d = wreq.data[2:0];
                UMFC_OFS_CHG1: thr_d = (wreq.data[3:0] > UMFC_THR_MAX) ? UMFC_THR_MAX : wreq.data[3:0];
                UMFC_OFS_LV1: lv1_rts_d = wreq.data[UMFC_LV1_RTS];
                UMFC_OFS_LV2: lv2_dtr_d = wreq.data[UMFC_LV2_DTR];
                default: ;
            endcase
        end
        // Overrun is sticky; a new overrun beats the clear by a status read
        ovr_d = ovr_q;
        if (rreq.en && (rreq.addr == UMFC_OFS_STAT))
            ovr_d = 1'b0;
        if (rx_push && rx_full)
            ovr_d = 1'b1;
    end

    // Pin drivers: compared afresh every cycle, registered once
    always_comb
    begin
        if (thr_q != UMFC_THR_OFF)
            dtr_b_d = !(rx_en && (rx_level < thr_q));
        else
            dtr_b_d = !lv2_dtr_q;
        if (req_auto)
            rts_b_d = !tx_pending;
        else
            rts_b_d = !lv1_rts_q;
    end

    always_comb
    begin
        rok = 1'b1;
        rdata = '0;
        unique case (rreq.addr)
            UMFC_OFS_CTRL: rdata[1:0] = ctrl_q;
            UMFC_OFS_OPT2: rdata[2:0] = opt2_q;
            UMFC_OFS_CHG1: rdata[3:0] = thr_q;
            UMFC_OFS_LV1:
            begin
                rdata[UMFC_LV1_RTS] = !rts_b_q;
                rdata[UMFC_LV1_CTS] = cts_on;
                rdata[UMFC_LV1_DSR] = dsr_on;
            end
            UMFC_OFS_LV2:
            begin
                rdata[UMFC_LV2_DTR] = !dtr_b_q;
                rdata[UMFC_LV2_DSR] = dsr_on;
            end
            UMFC_OFS_TXD: rdata[UMFC_LVL_W-1:0] = tx_level;
            UMFC_OFS_RXD: rdata[UMFC_CHAR_W-1:0] = rx_empty ? '0 : rx_head;
            UMFC_OFS_SPC: rdata[UMFC_CHAR_W:0] = {spc_v_q, spc_q};
            UMFC_OFS_STAT:
            begin
                rdata[UMFC_LVL_W-1:0] = rx_level;
                rdata[UMFC_STAT_TXLVL +: UMFC_LVL_W] = tx_level;
                rdata[UMFC_STAT_HOLD] = hold_v_q;
                rdata[UMFC_STAT_OVR] = ovr_q;
            end
            default: rok = 1'b0;
        endcase
    end

    assign wok = (wreq.addr == UMFC_OFS_CTRL) || (wreq.addr == UMFC_OFS_OPT2) ||
        (wreq.addr == UMFC_OFS_CHG1) || (wreq.addr == UMFC_OFS_LV1) || (wreq.addr == UMFC_OFS_LV2) ||
        (wreq.addr == UMFC_OFS_TXD) || (wreq.addr == UMFC_OFS_SPC);

    always_ff @(posedge i_sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_q <= UMFC_CTRL_RST;
            opt2_q <= UMFC_OPT2_RST;
            thr_q <= UMFC_THR_OFF;
            lv1_rts_q <= 1'b0;
            lv2_dtr_q <= 1'b0;
            ovr_q <= 1'b0;
            spc_v_q <= 1'b0;
            spc_q <= '0;
            hold_v_q <= 1'b0;
            hold_q <= '0;
            rts_b_q <= 1'b1;
            dtr_b_q <= 1'b1;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            opt2_q <= opt2_d;
            thr_q <= thr_d;
            lv1_rts_q <= lv1_rts_d;
            lv2_dtr_q <= lv2_dtr_d;
            ovr_q <= ovr_d;
            spc_v_q <= spc_v_d;
            spc_q <= spc_d;
            hold_v_q <= hold_v_d;
            hold_q <= hold_d;
            rts_b_q <= rts_b_d;
            dtr_b_q <= dtr_b_d;
        end
    end

    assign o_rts_b = rts_b_q;
    assign o_dtr_b = dtr_b_q;
    assign o_tx_valid = hold_v_q;
    assign o_tx_char = hold_q;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!rst_b);

    sequence s_spc_ready;
        spc_v_q && !hold_v_q;
    endsequence

    sequence s_cts_back;
        clr_gate && !i_cts_b && tx_en && !tx_empty && !hold_v_q && !spc_v_q;
    endsequence

    sequence s_gate_closed;
        clr_gate && i_cts_b && !hold_v_q && !spc_v_q;
    endsequence

    a_dtr_below_thr: assert property ((thr_q != 4'h0) && rx_en && (rx_level < thr_q) |=> !o_dtr_b)
        else $error("DTR not asserted below threshold");
    a_dtr_at_thr: assert property ((thr_q != 4'h0) && (rx_level >= thr_q) |=> o_dtr_b)
        else $error("DTR asserted at or above threshold");
    a_dtr_manual_bit: assert property ((thr_q == 4'h0) |=> (o_dtr_b == !$past(lv2_dtr_q)))
        else $error("Manual DTR not followed");
    a_rx_dsr_discard: assert property (i_rx_valid && rx_gate && i_dsr_b |=> rx_level <= $past(rx_level))
        else $error("Character kept while DSR deasserted");
    a_rts_auto_on: assert property (req_auto && !tx_empty |=> !o_rts_b)
        else $error("RTS not asserted with pending data");
    a_rts_auto_off: assert property (req_auto && !tx_pending |=> o_rts_b)
        else $error("RTS asserted with nothing to send");
    a_rts_manual_bit: assert property (!req_auto |=> (o_rts_b == !$past(lv1_rts_q)))
        else $error("Manual RTS not followed");
    a_cts_blocks_load: assert property (s_gate_closed |=> !hold_v_q)
        else $error("FIFO data loaded while CTS deasserted");
    a_cts_resume_load: assert property (s_cts_back |=> hold_v_q && (hold_q == $past(tx_head)))
        else $error("Transmission did not resume with CTS");
    a_spc_bypass_gate: assert property (s_spc_ready |=> hold_v_q && (hold_q == $past(spc_q)))
        else $error("Special character not loaded");
endmodule

// File: test/umfc_remote.sv
// Remote end model: shifter, handshake pins and receive source
`timescale 1ns/1ps
module umfc_remote
    import umfc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_slow,
    input wire logic i_tx_valid,
    input wire logic [UMFC_CHAR_W-1:0] i_tx_char,
    output logic o_tx_ready,
    output logic o_tx_busy,
    input wire logic i_cts_off,
    output logic o_cts_b,
    input wire logic i_dsr_off,
    output logic o_dsr_b,
    input wire logic i_rx_go,
    input wire logic [UMFC_CHAR_W-1:0] i_rx_data,
    output logic o_rx_valid,
    output logic [UMFC_CHAR_W-1:0] o_rx_char,
    output int o_sent,
    output logic [UMFC_CHAR_W-1:0] o_last
);
    int busy_q;
    // Shifter refuses a new character until the current one has gone
    assign o_tx_ready = busy_q == 0;
    assign o_tx_busy = busy_q != 0;
    assign o_cts_b = i_cts_off;
    assign o_dsr_b = i_dsr_off;
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            busy_q <= 0;
            o_sent <= 0;
            o_last <= 8'h00;
            o_rx_valid <= 1'b0;
            o_rx_char <= 8'h00;
        end
        else
        begin
            o_rx_valid <= i_rx_go;
            // Line churns between characters so a stale value never looks valid
            o_rx_char <= i_rx_go ? i_rx_data : ~o_rx_char;
            if (i_tx_valid && o_tx_ready)
            begin
                busy_q <= i_slow ? 12 : 2;
                o_sent <= o_sent + 1;
                o_last <= i_tx_char;
            end
            else if (busy_q != 0)
                busy_q <= busy_q - 1;
        end
    end
endmodule

// File: test/umfc_test.sv
// Self-checking bench for the modem flow control block
`timescale 1ns/1ps
module umfc_test
    import umfc_pkg::*;
;
    logic clk = 0;
    logic rst_b = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic cts_off = 0, dsr_off = 0, rx_go = 0, slow = 0;
    logic [7:0] awaddr = 0, araddr = 0, rxd = 0;
    logic [31:0] wdata = 0;
    logic awready, wready, bvalid, arready, rvalid, rts_b, dtr_b, txv, txr, txb, ctsb, dsrb, rxv;
    logic [1:0] bresp, rresp, r;
    logic [7:0] txc, rxc, last;
    logic [31:0] rdata, d;
    int sent, mismatches = 0, cmp_count = 0, cyc = 0;

    umfc_top i_dut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_awvalid(awvalid), .o_awready(awready),
        .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(4'hf),
        .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
        .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
        .i_rx_valid(rxv), .i_rx_char(rxc), .o_tx_valid(txv), .o_tx_char(txc), .i_tx_ready(txr),
        .i_tx_busy(txb), .i_cts_b(ctsb), .i_dsr_b(dsrb), .o_rts_b(rts_b), .o_dtr_b(dtr_b));
    umfc_remote i_far (.i_clk(clk), .i_rst_b(rst_b), .i_slow(slow), .i_tx_valid(txv), .i_tx_char(txc),
        .o_tx_ready(txr), .o_tx_busy(txb), .i_cts_off(cts_off), .o_cts_b(ctsb), .i_dsr_off(dsr_off),
        .o_dsr_b(dsrb), .i_rx_go(rx_go), .i_rx_data(rxd), .o_rx_valid(rxv), .o_rx_char(rxc),
        .o_sent(sent), .o_last(last));

    initial
    begin
        forever #10 clk = ~clk;
    end

    task automatic tk(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do
        begin
            @(posedge clk);
            if (awready)
                awvalid <= 0;
            if (wready)
                wvalid <= 0;
        end
        while (!bvalid);
        bready <= 0;
        r = bresp;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do
        begin
            @(posedge clk);
            if (arready)
                arvalid <= 0;
        end
        while (!rvalid);
        rready <= 0;
        d = rdata;
        r = rresp;
    endtask

    task automatic rx(input logic [7:0] c);
        @(posedge clk);
        rx_go <= 1;
        rxd <= c;
        @(posedge clk);
        rx_go <= 0;
        tk(2);
    endtask

    task automatic ws(input int n);
        int k;
        k = 0;
        while (sent < n && k < 200)
        begin
            @(posedge clk);
            k++;
        end
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Whole run needs under a thousand cycles; the ceiling of 20000 leaves ample margin
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            end_of_test;
        end
    end

    initial
    begin
        tk(6);
        rst_b <= 1;
        tk(4);
        chk("rts idle", 1, rts_b);
        chk("dtr idle", 1, dtr_b);
        rd(8'h24);
        chk("unmapped", UMFC_RESP_SLVERR, r);
        wr(UMFC_OFS_RXD, 0);
        chk("rxd write", UMFC_RESP_SLVERR, r);
        $display("test bus done");
        wr(UMFC_OFS_CTRL, 3);
        wr(UMFC_OFS_CHG1, 32'h0f);
        rd(UMFC_OFS_CHG1);
        chk("clamp", UMFC_THR_MAX, d[3:0]);
        wr(UMFC_OFS_CHG1, 2);
        tk(3);
        chk("dtr empty", 0, dtr_b);
        rx(8'h41);
        tk(1);
        chk("dtr one", 0, dtr_b);
        rx(8'h42);
        tk(1);
        chk("dtr full", 1, dtr_b);
        rd(UMFC_OFS_STAT);
        chk("rx level", 2, d[3:0]);
        rd(UMFC_OFS_RXD);
        chk("rx head", 8'h41, d);
        tk(3);
        chk("dtr pop", 0, dtr_b);
        rd(UMFC_OFS_RXD);
        chk("rx next", 8'h42, d);
        wr(UMFC_OFS_CHG1, 0);
        wr(UMFC_OFS_LV2, 2);
        tk(2);
        chk("dtr hand", 0, dtr_b);
        wr(UMFC_OFS_LV2, 0);
        tk(2);
        chk("dtr hand off", 1, dtr_b);
        wr(UMFC_OFS_OPT2, 1);
        dsr_off <= 1;
        rx(8'h51);
        rd(UMFC_OFS_STAT);
        chk("gate drop", 0, d[3:0]);
        rd(UMFC_OFS_LV2);
        chk("dsr off", 0, d[5]);
        dsr_off <= 0;
        rx(8'h52);
        rd(UMFC_OFS_RXD);
        chk("gate pass", 8'h52, d);
        // Thirteenth character finds the FIFO full and must leave a sticky overrun
        repeat (13) rx(8'h33);
        rd(UMFC_OFS_STAT);
        chk("overrun set", 32'h0002000c, d);
        rd(UMFC_OFS_STAT);
        chk("overrun clear", 0, d[UMFC_STAT_OVR]);
        $display("test receive done");
        slow <= 1;
        wr(UMFC_OFS_OPT2, 4);
        wr(UMFC_OFS_TXD, 8'h61);
        tk(2);
        chk("rts auto", 0, rts_b);
        ws(1);
        tk(20);
        chk("rts drop", 1, rts_b);
        wr(UMFC_OFS_OPT2, 0);
        wr(UMFC_OFS_LV1, 1);
        tk(2);
        chk("rts hand", 0, rts_b);
        rd(UMFC_OFS_LV1);
        chk("cts on", 1, d[4]);
        wr(UMFC_OFS_LV1, 0);
        tk(2);
        chk("rts hand off", 1, rts_b);
        wr(UMFC_OFS_OPT2, 2);
        wr(UMFC_OFS_TXD, 8'h71);
        wr(UMFC_OFS_TXD, 8'h72);
        ws(2);
        tk(4);
        cts_off <= 1;
        wr(UMFC_OFS_TXD, 8'h73);
        wr(UMFC_OFS_TXD, 8'h74);
        tk(60);
        chk("held goes", 3, sent);
        chk("held char", 8'h72, last);
        cts_off <= 0;
        ws(5);
        chk("resume", 5, sent);
        chk("resume char", 8'h74, last);
        cts_off <= 1;
        rd(UMFC_OFS_LV1);
        chk("cts off", 0, d[4]);
        wr(UMFC_OFS_SPC, 8'h5a);
        ws(6);
        chk("special", 8'h5a, last);
        $display("test transmit done");
        end_of_test;
    end
endmodule
